// [design/cfr_core_regs.sv]
// Flags, program counter and pointer registers of the 8-bit core
// Operation
// - Carry flag set on add carry, no borrow, rotate-out one, compare >= 0.
// - Nibble carry set on low nibble add carry or nibble subtract without borrow.
// - Zero flag follows whether an arithmetic, logic or branch result is zero.
// - Status register holds three flags, software read/write, zero after reset.
// - Counter is 14 bits, six high and eight low, zero after reset.
// - Counter advances by one after each ordinary instruction.
// - Absolute jump loads the target into counter bits 10 down to 0.
// - The nine skip instructions advance the counter by two when true.
// - Bit-test skip happens when tested bit equals the instruction polarity.
// - Compare-and-skip skips when accumulator equals the operand.
// - Increment-and-skip skips on wrap from FF to 00; result to acc or memory.
// - Decrement-and-skip skips on wrap from 00 to FF; result to acc or memory.
// - Low byte writes jump within the region; no carry into high byte.
// - First pointer pair is two 8-bit registers, bank high, location low.
// - Extra pointer is an 8-bit register cleared at reset, also ROM pointer.
// - Second pointer pair serves as general, indirect RAM and ROM pointer.
// - Table read puts word high byte in table register, low in accumulator.
`include "cfr_params.svh"

module cfr_core_regs #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0]      s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Instruction completion from the core
	input  wire logic                   exec_valid,
	input  wire cfr_pkg::cfr_op_t       exec_op,
	input  wire logic [10:0]            jump_target,
	input  wire logic [7:0]             accumulator,
	input  wire logic [7:0]             operand,
	input  wire logic                   tested_bit,
	input  wire logic [15:0]            rom_word,
	// Flags from other ALU operations
	input  wire logic                   alu_flag_we,
	input  wire logic [2:0]             alu_flags_in,
	// Results towards the core
	output logic [13:0]                 program_counter,
	output logic [2:0]                  alu_status_flags,
	output logic [7:0]                  result_data,
	output logic                        accumulator_load,
	output logic                        memory_write,
	output logic                        skip_taken,
	// Pointer views
	output logic [15:0]                 first_indirect_port,
	output logic [15:0]                 second_indirect_port,
	output logic [23:0]                 rom_table_pointer
);
	import cfr_pkg::*;

	// ****************************************
	// Register storage
	// ****************************************
	logic [7:0]  ram_pointer_low_ff;
	logic [7:0]  ram_pointer_high_ff;
	logic [7:0]  table_read_high_byte_ff;
	logic [7:0]  second_pointer_low_ff;
	logic [7:0]  second_pointer_high_ff;
	logic [7:0]  rom_extra_pointer_ff;
	logic [2:0]  alu_status_flags_ff;
	logic [2:0]  nxt_alu_status_flags;
	logic [13:0] program_counter_ff;
	logic [13:0] nxt_program_counter;
	logic [7:0]  result_data_ff;
	logic [7:0]  nxt_result_data;
	logic        accumulator_load_ff;
	logic        memory_write_ff;
	logic        skip_taken_ff;
	logic        skip_cond;
	logic        result_to_acc;
	logic        result_to_mem;
	logic        flag_update;
	logic [8:0]  add_sum;
	logic [8:0]  sub_diff;
	logic [7:0]  inc_value;
	logic [7:0]  dec_value;

	// ****************************************
	// Bus side state
	// ****************************************
	logic [ADDR_W-1:0] awaddr_ff;
	logic              aw_held_ff;
	logic [7:0]        wdata_ff;
	logic              wstrb_low_ff;
	logic              w_held_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              rvalid_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        rresp_ff;
	logic              wr_do;
	cfr_sel_t          wr_sel;
	cfr_sel_t          rd_sel;
	logic [7:0]        rd_byte;

	// Word address must be aligned and inside the low range
	function automatic cfr_sel_t reg_decode(input logic [ADDR_W-1:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		if (addr[1:0] != 2'h0 || addr[ADDR_W-1:10] != '0) begin
			return SEL_NONE;
		end else if (idx == `CFR_IDX_RAM_POINTER_LOW) begin
			return SEL_RAM_POINTER_LOW;
		end else if (idx == `CFR_IDX_RAM_POINTER_HIGH) begin
			return SEL_RAM_POINTER_HIGH;
		end else if (idx == `CFR_IDX_TABLE_READ_HIGH) begin
			return SEL_TABLE_READ_HIGH;
		end else if (idx == `CFR_IDX_SECOND_POINTER_LOW) begin
			return SEL_SECOND_POINTER_LOW;
		end else if (idx == `CFR_IDX_SECOND_POINTER_HIGH) begin
			return SEL_SECOND_POINTER_HIGH;
		end else if (idx == `CFR_IDX_ROM_EXTRA_POINTER) begin
			return SEL_ROM_EXTRA_POINTER;
		end else if (idx == `CFR_IDX_ALU_STATUS_FLAGS) begin
			return SEL_ALU_STATUS_FLAGS;
		end else if (idx == `CFR_IDX_COUNTER_LOW_BYTE) begin
			return SEL_COUNTER_LOW_BYTE;
		end else if (idx == `CFR_IDX_COUNTER_HIGH_BYTE) begin
			return SEL_COUNTER_HIGH_BYTE;
		end else begin
			return SEL_NONE;
		end
	endfunction

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign s_axi_awready = !aw_held_ff;
	assign s_axi_wready  = !w_held_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	// Write commits once both halves are in and no response is pending
	assign wr_do  = aw_held_ff && w_held_ff && !bvalid_ff;
	assign wr_sel = reg_decode(awaddr_ff);
	assign rd_sel = reg_decode(s_axi_araddr);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff   <= 1'b0;
			awaddr_ff    <= '0;
			w_held_ff    <= 1'b0;
			wdata_ff     <= 8'h00;
			wstrb_low_ff <= 1'b0;
		end else begin
			if (s_axi_awvalid && !aw_held_ff) begin
				aw_held_ff <= 1'b1;
				awaddr_ff  <= s_axi_awaddr;
			end else if (wr_do) begin
				aw_held_ff <= 1'b0;
			end
			if (s_axi_wvalid && !w_held_ff) begin
				w_held_ff    <= 1'b1;
				wdata_ff     <= s_axi_wdata[7:0];
				wstrb_low_ff <= s_axi_wstrb[0];
			end else if (wr_do) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= `CFR_RESP_OKAY;
		end else if (wr_do) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= (wr_sel == SEL_NONE) ? `CFR_RESP_SLVERR : `CFR_RESP_OKAY;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	always_comb begin
		case (rd_sel)
			SEL_RAM_POINTER_LOW:     rd_byte = ram_pointer_low_ff;
			SEL_RAM_POINTER_HIGH:    rd_byte = ram_pointer_high_ff;
			SEL_TABLE_READ_HIGH:     rd_byte = table_read_high_byte_ff;
			SEL_SECOND_POINTER_LOW:  rd_byte = second_pointer_low_ff;
			SEL_SECOND_POINTER_HIGH: rd_byte = second_pointer_high_ff;
			SEL_ROM_EXTRA_POINTER:   rd_byte = rom_extra_pointer_ff;
			SEL_ALU_STATUS_FLAGS:    rd_byte = {5'h00, alu_status_flags_ff};
			SEL_COUNTER_LOW_BYTE:    rd_byte = program_counter_ff[7:0];
			SEL_COUNTER_HIGH_BYTE:   rd_byte = {2'h0, program_counter_ff[13:8]};
			default:                 rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= `CFR_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= {24'h000000, rd_byte};
			rresp_ff  <= (rd_sel == SEL_NONE) ? `CFR_RESP_SLVERR : `CFR_RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ****************************************
	// Instruction effects
	// ****************************************
	assign add_sum   = {1'b0, accumulator} + {1'b0, operand};
	assign sub_diff  = {1'b0, accumulator} - {1'b0, operand};
	assign inc_value = operand + 8'h01;
	assign dec_value = operand - 8'h01;

	always_comb begin
		skip_cond            = 1'b0;
		result_to_acc        = 1'b0;
		result_to_mem        = 1'b0;
		flag_update          = 1'b0;
		nxt_result_data      = result_data_ff;
		nxt_alu_status_flags = alu_status_flags_ff;
		if (exec_valid) begin
			case (exec_op)
				OP_ADD: begin
					flag_update     = 1'b1;
					result_to_acc   = 1'b1;
					nxt_result_data = add_sum[7:0];
					nxt_alu_status_flags[`CFR_BIT_CARRY] = add_sum[8];
					nxt_alu_status_flags[`CFR_BIT_NIBBLE] =
						({1'b0, accumulator[3:0]} + {1'b0, operand[3:0]}) > 5'h0F;
					nxt_alu_status_flags[`CFR_BIT_ZERO] = (add_sum[7:0] == 8'h00);
				end
				OP_SUBTRACT: begin
					flag_update     = 1'b1;
					result_to_acc   = 1'b1;
					nxt_result_data = sub_diff[7:0];
					nxt_alu_status_flags[`CFR_BIT_CARRY] = !sub_diff[8];
					nxt_alu_status_flags[`CFR_BIT_NIBBLE] = accumulator[3:0] >= operand[3:0];
					nxt_alu_status_flags[`CFR_BIT_ZERO]   = (sub_diff[7:0] == 8'h00);
				end
				OP_ROTATE_LEFT: begin
					flag_update     = 1'b1;
					result_to_acc   = 1'b1;
					nxt_result_data = {accumulator[6:0], alu_status_flags_ff[`CFR_BIT_CARRY]};
					nxt_alu_status_flags[`CFR_BIT_CARRY] = accumulator[7];
				end
				OP_COMPARE_AND_SKIP: begin
					flag_update = 1'b1;
					skip_cond   = (accumulator == operand);
					nxt_alu_status_flags[`CFR_BIT_CARRY] = accumulator >= operand;
					nxt_alu_status_flags[`CFR_BIT_ZERO]  = (accumulator == operand);
				end
				OP_INCREMENT_SKIP_TO_ACC, OP_INCREMENT_SKIP_TO_MEM: begin
					skip_cond       = (operand == 8'hFF);
					nxt_result_data = inc_value;
					result_to_acc   = (exec_op == OP_INCREMENT_SKIP_TO_ACC);
					result_to_mem   = (exec_op == OP_INCREMENT_SKIP_TO_MEM);
				end
				OP_DECREMENT_SKIP_TO_ACC, OP_DECREMENT_SKIP_TO_MEM: begin
					skip_cond       = (operand == 8'h00);
					nxt_result_data = dec_value;
					result_to_acc   = (exec_op == OP_DECREMENT_SKIP_TO_ACC);
					result_to_mem   = (exec_op == OP_DECREMENT_SKIP_TO_MEM);
				end
				OP_BIT_TEST_SKIP_IF_ZERO, OP_BANK0_BIT_SKIP_IF_ZERO: skip_cond = !tested_bit;
				OP_BIT_TEST_SKIP_IF_ONE, OP_BANK0_BIT_SKIP_IF_ONE:   skip_cond = tested_bit;
				OP_ROM_TABLE_READ: begin
					result_to_acc   = 1'b1;
					nxt_result_data = rom_word[7:0];
				end
				default: skip_cond = 1'b0;
			endcase
		end
		// all three flags from other ALU operations
		if (!flag_update && alu_flag_we) begin
			nxt_alu_status_flags = alu_flags_in;
		end
	end

	// Hardware flag update outranks a software write in the same cycle
	// flags readable and writable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alu_status_flags_ff <= `CFR_RST_FLAGS;
		end else if (exec_valid && flag_update || alu_flag_we) begin
			alu_status_flags_ff <= nxt_alu_status_flags;
		end else if (wr_do && wstrb_low_ff && wr_sel == SEL_ALU_STATUS_FLAGS) begin
			alu_status_flags_ff <= wdata_ff[2:0];
		end
	end

	always_comb begin
		nxt_program_counter = program_counter_ff;
		if (wr_do && wstrb_low_ff && wr_sel == SEL_COUNTER_LOW_BYTE) begin
			nxt_program_counter = {program_counter_ff[13:8], wdata_ff};
		end else if (wr_do && wstrb_low_ff && wr_sel == SEL_COUNTER_HIGH_BYTE) begin
			nxt_program_counter = {wdata_ff[5:0], program_counter_ff[7:0]};
		end else if (exec_valid) begin
			if (exec_op == OP_ABSOLUTE_JUMP) begin
				nxt_program_counter = {program_counter_ff[13:11], jump_target};
			end else if (skip_cond) begin
				nxt_program_counter = program_counter_ff + 14'h0002;
			end else begin
				nxt_program_counter = program_counter_ff + 14'h0001;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			program_counter_ff <= `CFR_RST_COUNTER;
		end else begin
			program_counter_ff <= nxt_program_counter;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			result_data_ff      <= 8'h00;
			accumulator_load_ff <= 1'b0;
			memory_write_ff     <= 1'b0;
			skip_taken_ff       <= 1'b0;
		end else begin
			result_data_ff      <= nxt_result_data;
			accumulator_load_ff <= result_to_acc;
			memory_write_ff     <= result_to_mem;
			skip_taken_ff       <= skip_cond;
		end
	end

	// ****************************************
	// Working and pointer registers
	// ****************************************
	// Contents are undefined after reset, so no reset term here
	// first and second pointer pairs
	always_ff @(posedge aclk) begin
		if (wr_do && wstrb_low_ff) begin
			if (wr_sel == SEL_RAM_POINTER_LOW) ram_pointer_low_ff <= wdata_ff;
			if (wr_sel == SEL_RAM_POINTER_HIGH) ram_pointer_high_ff <= wdata_ff;
			if (wr_sel == SEL_SECOND_POINTER_LOW) second_pointer_low_ff <= wdata_ff;
			if (wr_sel == SEL_SECOND_POINTER_HIGH) second_pointer_high_ff <= wdata_ff;
		end
	end

	// high byte capture wins over software
	always_ff @(posedge aclk) begin
		if (exec_valid && exec_op == OP_ROM_TABLE_READ) begin
			table_read_high_byte_ff <= rom_word[15:8];
		end else if (wr_do && wstrb_low_ff && wr_sel == SEL_TABLE_READ_HIGH) begin
			table_read_high_byte_ff <= wdata_ff;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rom_extra_pointer_ff <= `CFR_RST_EXTRA_POINTER;
		end else if (wr_do && wstrb_low_ff && wr_sel == SEL_ROM_EXTRA_POINTER) begin
			rom_extra_pointer_ff <= wdata_ff;
		end
	end

	assign program_counter      = program_counter_ff;
	assign alu_status_flags     = alu_status_flags_ff;
	assign result_data          = result_data_ff;
	assign accumulator_load     = accumulator_load_ff;
	assign memory_write         = memory_write_ff;
	assign skip_taken           = skip_taken_ff;
	assign first_indirect_port  = {ram_pointer_high_ff, ram_pointer_low_ff};
	// second pair as RAM and ROM pointer
	assign second_indirect_port = {second_pointer_high_ff, second_pointer_low_ff};
	assign rom_table_pointer    = {rom_extra_pointer_ff, second_pointer_high_ff,
		second_pointer_low_ff};

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic counter_bus_write;
	assign counter_bus_write = wr_do && wstrb_low_ff &&
		(wr_sel == SEL_COUNTER_LOW_BYTE || wr_sel == SEL_COUNTER_HIGH_BYTE);

	property p_add_carry;
		exec_valid && exec_op == OP_ADD |=>
			alu_status_flags_ff[`CFR_BIT_CARRY] ==
				(({1'b0, $past(accumulator)} + {1'b0, $past(operand)}) > 9'h0FF);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry wrong after add");

	property p_add_nibble;
		exec_valid && exec_op == OP_ADD && accumulator[3:0] == 4'hF && operand[3:0] == 4'h1 |=>
			alu_status_flags_ff[`CFR_BIT_NIBBLE];
	endproperty
	a_add_nibble: assert property (p_add_nibble) else $error("nibble carry missed");

	property p_compare_zero;
		exec_valid && exec_op == OP_COMPARE_AND_SKIP |=>
			alu_status_flags_ff[`CFR_BIT_ZERO] == ($past(accumulator) == $past(operand));
	endproperty
	a_compare_zero: assert property (p_compare_zero) else $error("zero flag wrong");

	property p_reset_values;
		!$past(aresetn) |-> program_counter_ff == 14'h0000 && alu_status_flags_ff == 3'h0
			&& rom_extra_pointer_ff == 8'h00;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

	property p_step_one;
		exec_valid && exec_op == OP_NEXT && !counter_bus_write |=>
			program_counter_ff == $past(program_counter_ff) + 14'h0001;
	endproperty
	a_step_one: assert property (p_step_one) else $error("counter did not step");

	property p_jump_load;
		exec_valid && exec_op == OP_ABSOLUTE_JUMP && !counter_bus_write |=>
			program_counter_ff[10:0] == $past(jump_target) &&
			program_counter_ff[13:11] == $past(program_counter_ff[13:11]);
	endproperty
	a_jump_load: assert property (p_jump_load) else $error("jump target not loaded");

	property p_skip_two;
		exec_valid && skip_cond && !counter_bus_write |=>
			program_counter_ff == $past(program_counter_ff) + 14'h0002 ##0 skip_taken_ff;
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("skip did not add two");

	property p_bit_skip;
		exec_valid && (exec_op == OP_BIT_TEST_SKIP_IF_ONE || exec_op == OP_BANK0_BIT_SKIP_IF_ONE)
			|=> skip_taken_ff == $past(tested_bit);
	endproperty
	a_bit_skip: assert property (p_bit_skip) else $error("bit test polarity wrong");

	property p_compare_skip;
		exec_valid && exec_op == OP_COMPARE_AND_SKIP && accumulator != operand |=> !skip_taken_ff;
	endproperty
	a_compare_skip: assert property (p_compare_skip) else $error("compare skipped wrongly");

	property p_inc_wrap;
		exec_valid && exec_op == OP_INCREMENT_SKIP_TO_MEM && operand == 8'hFF |=>
			skip_taken_ff && memory_write_ff && result_data_ff == 8'h00;
	endproperty
	a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap missed");

	property p_dec_wrap;
		exec_valid && exec_op == OP_DECREMENT_SKIP_TO_ACC && operand == 8'h00 |=>
			skip_taken_ff && accumulator_load_ff && result_data_ff == 8'hFF;
	endproperty
	a_dec_wrap: assert property (p_dec_wrap) else $error("decrement wrap missed");

	property p_low_write;
		wr_do && wstrb_low_ff && wr_sel == SEL_COUNTER_LOW_BYTE |=>
			program_counter_ff == {$past(program_counter_ff[13:8]), $past(wdata_ff)};
	endproperty
	a_low_write: assert property (p_low_write) else $error("high byte changed");

	property p_table_read;
		exec_valid && exec_op == OP_ROM_TABLE_READ |=>
			table_read_high_byte_ff == $past(rom_word[15:8]) &&
			result_data_ff == $past(rom_word[7:0]) && accumulator_load_ff;
	endproperty
	a_table_read: assert property (p_table_read) else $error("table read bytes wrong");

endmodule // cfr_core_regs

// [design/cfr_params.svh]
// Offsets, field positions and reset values of the core state registers
`ifndef CFR_PARAMS_SVH
`define CFR_PARAMS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define CFR_IDX_RAM_POINTER_LOW     8'h80
`define CFR_IDX_RAM_POINTER_HIGH    8'h81
`define CFR_IDX_TABLE_READ_HIGH     8'h82
`define CFR_IDX_SECOND_POINTER_LOW  8'h83
`define CFR_IDX_SECOND_POINTER_HIGH 8'h84
`define CFR_IDX_ROM_EXTRA_POINTER   8'h85
`define CFR_IDX_ALU_STATUS_FLAGS    8'h86
`define CFR_IDX_COUNTER_LOW_BYTE    8'hCE
`define CFR_IDX_COUNTER_HIGH_BYTE   8'hCF

// ****************************************
// Flag field positions
// ****************************************
`define CFR_BIT_CARRY  2
`define CFR_BIT_NIBBLE 1
`define CFR_BIT_ZERO   0

// ****************************************
// Reset values and bus answers
// ****************************************
`define CFR_RST_FLAGS         3'h0
`define CFR_RST_EXTRA_POINTER 8'h00
`define CFR_RST_COUNTER       14'h0000
`define CFR_RESP_OKAY         2'h0
`define CFR_RESP_SLVERR       2'h2

`endif

// [design/cfr_pkg.sv]
// Types shared by the core state register block
package cfr_pkg;

	// ****************************************
	// Instruction kinds reported by the core
	// ****************************************
	typedef enum logic [3:0] {
		OP_NEXT,
		OP_ABSOLUTE_JUMP,
		OP_ADD,
		OP_SUBTRACT,
		OP_ROTATE_LEFT,
		OP_COMPARE_AND_SKIP,
		OP_INCREMENT_SKIP_TO_ACC,
		OP_INCREMENT_SKIP_TO_MEM,
		OP_DECREMENT_SKIP_TO_ACC,
		OP_DECREMENT_SKIP_TO_MEM,
		OP_BIT_TEST_SKIP_IF_ZERO,
		OP_BIT_TEST_SKIP_IF_ONE,
		OP_BANK0_BIT_SKIP_IF_ZERO,
		OP_BANK0_BIT_SKIP_IF_ONE,
		OP_ROM_TABLE_READ
	} cfr_op_t;

	// ****************************************
	// Register selection
	// ****************************************
	typedef enum logic [3:0] {
		SEL_NONE,
		SEL_RAM_POINTER_LOW,
		SEL_RAM_POINTER_HIGH,
		SEL_TABLE_READ_HIGH,
		SEL_SECOND_POINTER_LOW,
		SEL_SECOND_POINTER_HIGH,
		SEL_ROM_EXTRA_POINTER,
		SEL_ALU_STATUS_FLAGS,
		SEL_COUNTER_LOW_BYTE,
		SEL_COUNTER_HIGH_BYTE
	} cfr_sel_t;

endpackage

// [tb/tb.sv]
// Self-checking bench for the core state register block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cfr_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, exec_valid, tested_bit;
	logic alu_flag_we, accumulator_load, memory_write, skip_taken, s;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [31:0] v[7];
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	cfr_op_t exec_op;
	logic [10:0] jump_target;
	logic [7:0] accumulator, operand, result_data, a, o;
	logic [15:0] rom_word, first_indirect_port, second_indirect_port;
	logic [2:0] alu_flags_in, alu_status_flags;
	logic [13:0] program_counter, pc;
	logic [23:0] rom_table_pointer;
	integer seed = 96826, bad_count = 0, check_count = 0, cyc = 0;
	cfr_core_regs cfr_core_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.exec_valid, .exec_op, .jump_target, .accumulator, .operand, .tested_bit,
		.rom_word, .alu_flag_we, .alu_flags_in, .program_counter, .alu_status_flags,
		.result_data, .accumulator_load, .memory_write, .skip_taken,
		.first_indirect_port, .second_indirect_port, .rom_table_pointer);
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// Cuts a hung handshake short
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count = bad_count + 1;
			end_sim;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task end_sim;
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] w);
		@(posedge aclk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= w;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] ad);
		@(posedge aclk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Side inputs get fresh random values on every instruction
	task automatic ex(input cfr_op_t op, input logic [7:0] x, y, input logic b);
		@(posedge aclk);
		exec_valid <= 1'b1;
		exec_op <= op;
		accumulator <= x;
		operand <= y;
		tested_bit <= b;
		jump_target <= 11'($random(seed));
		rom_word <= 16'($random(seed));
		@(posedge aclk);
		exec_valid <= 1'b0;
		#1;
	endtask
	function automatic logic skp(cfr_op_t op, logic [7:0] x, y, logic b);
		case (op)
			OP_COMPARE_AND_SKIP: return x == y;
			OP_INCREMENT_SKIP_TO_ACC, OP_INCREMENT_SKIP_TO_MEM: return y == 8'hFF;
			OP_DECREMENT_SKIP_TO_ACC, OP_DECREMENT_SKIP_TO_MEM: return y == 8'h00;
			OP_BIT_TEST_SKIP_IF_ZERO, OP_BANK0_BIT_SKIP_IF_ZERO: return !b;
			OP_BIT_TEST_SKIP_IF_ONE, OP_BANK0_BIT_SKIP_IF_ONE: return b;
			default: return 1'b0;
		endcase
	endfunction
	// ****
	// Main sequence
	// ****
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{exec_valid, tested_bit, alu_flag_we, s_axi_awaddr, s_axi_araddr} = 27'h0;
		{s_axi_wdata, jump_target, accumulator, operand, rom_word} = 75'h0;
		s_axi_wstrb = 4'hF;
		exec_op = OP_NEXT;
		alu_flags_in = 3'h5;
		aresetn = 1'b0;
		pc = 14'h0000;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h218);
		chk(d, 32'h0);
		rd(12'h214);
		chk(d, 32'h0);
		chk(program_counter, 32'h0);
		for (int i = 0; i < 7; i++) begin
			v[i] = $random(seed);
			wr(12'(12'h200 + 4 * i), v[i]);
			rd(12'(12'h200 + 4 * i));
			chk(d, i == 6 ? v[i][2:0] : v[i][7:0]);
		end
		chk(first_indirect_port, {v[1][7:0], v[0][7:0]});
		chk(rom_table_pointer, {v[5][7:0], v[4][7:0], v[3][7:0]});
		chk(second_indirect_port, {v[4][7:0], v[3][7:0]});
		for (int i = 5; i < 14; i++)
			for (int k = 0; k < 3; k++) begin
				o = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
				a = (k == 2) ? o : 8'($random(seed));
				s = skp(cfr_op_t'(i), a, o, k[0]);
				ex(cfr_op_t'(i), a, o, k[0]);
				pc = pc + (s ? 14'h0002 : 14'h0001);
				chk(program_counter, pc);
				chk(skip_taken, s);
				chk({memory_write, accumulator_load}, {i == OP_INCREMENT_SKIP_TO_MEM ||
					i == OP_DECREMENT_SKIP_TO_MEM, i == OP_INCREMENT_SKIP_TO_ACC ||
					i == OP_DECREMENT_SKIP_TO_ACC});
				if (i > 5 && i < 10) chk(result_data, i < 8 ? 8'(o + 1) : 8'(o - 1));
				if (i == 5) chk({alu_status_flags[2], alu_status_flags[0]}, {a >= o, a == o});
			end
		for (int k = 0; k < 5; k++) begin
			a = k ? 8'($random(seed)) : 8'hFF;
			o = k ? 8'($random(seed)) : 8'h01;
			ex(OP_ADD, a, o, 1'b0);
			chk(alu_status_flags, {a + o > 9'h0FF, a[3:0] + o[3:0] > 5'h0F, a + o == 8'h00});
			chk(result_data, 8'(a + o));
			ex(OP_SUBTRACT, a, o, 1'b0);
			chk(alu_status_flags, {a >= o, a[3:0] >= o[3:0], a == o});
			pc = pc + 14'h0002;
		end
		ex(OP_ROM_TABLE_READ, a, o, 1'b0);
		chk({accumulator_load, result_data}, {1'b1, rom_word[7:0]});
		rd(12'h208);
		chk(d, rom_word[15:8]);
		pc = pc + 14'h0001;
		chk(program_counter, pc);
		alu_flag_we <= 1'b1;
		@(posedge aclk);
		alu_flag_we <= 1'b0;
		#1;
		chk(alu_status_flags, 3'h5);
		ex(OP_ROTATE_LEFT, a, o, 1'b0);
		chk({alu_status_flags, result_data}, {a[7], 2'b01, a[6:0], 1'b1});
		ex(OP_NEXT, a, o, 1'b0);
		pc = pc + 14'h0002;
		chk(program_counter, pc);
		v[0] = $random(seed);
		wr(12'h33C, v[0]);
		pc[13:8] = v[0][5:0];
		wr(12'h338, 32'h0000_00FF);
		pc[7:0] = 8'hFF;
		chk(program_counter, pc);
		ex(OP_ABSOLUTE_JUMP, a, o, 1'b0);
		chk(program_counter, {pc[13:11], jump_target});
		rd(12'h3FC);
		chk(r, 2'h2);
		end_sim;
	end
endmodule // tb
